// file: wdc_guard.sv
// Watchdog timer with timed unlock configuration and Avalon-MM registers.
`timescale 1ns/1ps
`default_nettype none
module wdc_guard
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        always_on_fuse,
  input  wire logic        osc_tick,
  input  wire logic        guard_kick,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_taken,
  output logic             guard_reset,
  output logic      [11:0] reset_vector_addr,
  output logic             timeout_irq_req,
  output logic      [11:0] irq_vector_addr,
  output logic             irq
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // One wait cycle per access keeps read data registered.
  logic ack_reg;
  logic wr_ctl;
  logic wr_en;
  logic wr_clr;
  logic [7:0] wd;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wd = avs_writedata[7:0];
  assign wr_ctl = avs_write & ack_reg & (avs_address == wdc_pkg::ADDR_CONTROL);
  assign wr_en  = avs_write & ack_reg & (avs_address == wdc_pkg::ADDR_IRQ_EN);
  assign wr_clr = avs_write & ack_reg & (avs_address == wdc_pkg::ADDR_IRQ_CLR);

  // Acknowledge toggles so back-to-back requests each see one wait cycle.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  // ****************************************************************
  // Control register and unlock window
  // ****************************************************************

  logic       enable_reg;
  logic       irq_enable_reg;
  logic       flag_reg;
  logic [3:0] sel_reg;
  logic       unlock_reg;
  logic [2:0] unlock_cnt_reg;
  logic       strap_done_reg;
  logic       level2_reg;
  logic       timeout;
  logic       run;
  logic [3:0] sel_wr;
  logic       flag_clr;
  logic       flag_set;
  logic       unlock_open;

  assign sel_wr = {wd[wdc_pkg::BIT_SEL3], wd[2:0]};
  assign run = level2_reg | enable_reg | irq_enable_reg;
  assign unlock_open = wr_ctl & wd[wdc_pkg::BIT_UNLOCK] & wd[wdc_pkg::BIT_ENABLE];

  // The fuse is caught once after reset release, never by the reset itself.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      strap_done_reg <= 1'b0;
      level2_reg     <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      level2_reg     <= always_on_fuse;
    end
  end

  // Unlock bit and its four-cycle window; a write of unlock with enable opens it.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end
    else if (unlock_open)
    begin
      unlock_reg     <= 1'b1;
      unlock_cnt_reg <= wdc_pkg::UNLOCK_CYCLES;
    end
    else if (unlock_cnt_reg == 3'h1)
    begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end
    else if (unlock_cnt_reg != 3'h0)
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
  end

  // Enable and selector: level 1 selector free, disable needs the window;
  // level 2 selector needs the window and enable stays set.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      enable_reg <= 1'b0;
      sel_reg    <= 4'h0;
    end
    else if (wr_ctl)
    begin
      if (wd[wdc_pkg::BIT_ENABLE])
        enable_reg <= 1'b1;
      else if (unlock_reg && !wd[wdc_pkg::BIT_UNLOCK] && !level2_reg)
        enable_reg <= 1'b0;
      if (!level2_reg || (unlock_reg && !wd[wdc_pkg::BIT_UNLOCK]))
        sel_reg <= (sel_wr > wdc_pkg::SEL_MAX) ? wdc_pkg::SEL_MAX : sel_wr;
    end
  end

  // Interrupt enable is cleared by a timeout while reset mode is also armed.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_enable_reg <= 1'b0;
    else if (timeout && (enable_reg || level2_reg))
      irq_enable_reg <= 1'b0;
    else if (wr_ctl)
      irq_enable_reg <= wd[wdc_pkg::BIT_IRQ_ENABLE];
  end

  // Timeout flag: the hardware set wins over any clear in the same cycle.
  assign flag_set = timeout & irq_enable_reg;
  assign flag_clr = (wr_ctl & wd[wdc_pkg::BIT_IRQ_FLAG]) | irq_taken;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flag_reg <= 1'b0;
    else if (flag_set)
      flag_reg <= 1'b1;
    else if (flag_clr)
      flag_reg <= 1'b0;
  end

  // ****************************************************************
  // Timer counter
  // ****************************************************************

  // Counts oscillator ticks; limit is 2^(11+sel). 21 bits hold 1024K.
  logic [20:0] count_reg;
  logic [20:0] limit;
  assign limit = 21'(21'h1 << (wdc_pkg::SEL_BASE_EXP + int'(sel_reg)));
  // Greater-or-equal, so a shorter period chosen mid-count still ends promptly.
  assign timeout = run & osc_tick & (count_reg >= limit - 21'h1);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      count_reg <= 21'h0;
    else if (guard_kick || !run || timeout)
      count_reg <= 21'h0;
    else if (osc_tick)
      count_reg <= count_reg + 21'h1;
  end

  // ****************************************************************
  // Outcome: reset or interrupt request
  // ****************************************************************

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      guard_reset <= 1'b0;
    else
      guard_reset <= timeout & ~irq_enable_reg & (enable_reg | level2_reg);
  end
  assign reset_vector_addr = wdc_pkg::RESET_VECTOR;
  assign irq_vector_addr   = wdc_pkg::TIMEOUT_VECTOR;
  assign timeout_irq_req   = flag_reg & irq_enable_reg & global_irq_enable;

  // ****************************************************************
  // Event status, enable and clear registers
  // ****************************************************************

  logic [wdc_pkg::EV_WIDTH-1:0] ev_stat_reg;
  logic [wdc_pkg::EV_WIDTH-1:0] ev_en_reg;
  logic [wdc_pkg::EV_WIDTH-1:0] ev_in;
  assign ev_in = {guard_reset, flag_set};

  // One sticky bit per event; a new event outranks a simultaneous clear.
  genvar gi;
  generate
    for (gi = 0; gi < wdc_pkg::EV_WIDTH; gi++)
    begin : g_ev
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          ev_stat_reg[gi] <= 1'b0;
        else if (ev_in[gi])
          ev_stat_reg[gi] <= 1'b1;
        else if (wr_clr && wd[gi])
          ev_stat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ev_en_reg <= '0;
    else if (wr_en)
      ev_en_reg <= wd[wdc_pkg::EV_WIDTH-1:0];
  end
  assign irq = |(ev_stat_reg & ev_en_reg);

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Unmapped addresses read zero; the clear register reads zero.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (avs_read && !ack_reg)
    begin
      case (avs_address)
        wdc_pkg::ADDR_CONTROL:
          avs_readdata <= {24'h0, flag_reg, irq_enable_reg, sel_reg[3], unlock_reg,
                           enable_reg | level2_reg, sel_reg[2:0]};
        wdc_pkg::ADDR_STATUS:
          avs_readdata <= {30'h0, ev_stat_reg};
        wdc_pkg::ADDR_IRQ_EN:
          avs_readdata <= {30'h0, ev_en_reg};
        default:
          avs_readdata <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_unlock_hold;
    @(posedge clk_sys) disable iff (rst) unlock_open |=> unlock_reg [*4];
  endproperty
  a_unlock_hold: assert property (p_unlock_hold) else $error("unlock window closed early");

  // A fresh unlock write inside the window restarts it, so only a quiet window must close.
  property p_unlock_close;
    @(posedge clk_sys) disable iff (rst)
      unlock_open ##1 (!unlock_open) [*4] |=> !unlock_reg;
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("unlock window length wrong");

  property p_sel_valid;
    @(posedge clk_sys) disable iff (rst) sel_reg <= wdc_pkg::SEL_MAX;
  endproperty
  a_sel_valid: assert property (p_sel_valid) else $error("reserved selector applied");

  property p_l2_enabled;
    @(posedge clk_sys) disable iff (rst)
      (level2_reg && avs_read && !ack_reg && avs_address == wdc_pkg::ADDR_CONTROL)
        |=> avs_readdata[wdc_pkg::BIT_ENABLE];
  endproperty
  a_l2_enabled: assert property (p_l2_enabled) else $error("level two enable read zero");

  property p_no_disable_locked;
    @(posedge clk_sys) disable iff (rst)
      (enable_reg && !unlock_reg) |=> enable_reg;
  endproperty
  a_no_disable_locked: assert property (p_no_disable_locked) else $error("disabled without unlock");

  property p_irq_not_reset;
    @(posedge clk_sys) disable iff (rst)
      (timeout && irq_enable_reg) |=> !guard_reset && flag_reg;
  endproperty
  a_irq_not_reset: assert property (p_irq_not_reset) else $error("timeout in irq mode reset");

  property p_reset_on_timeout;
    @(posedge clk_sys) disable iff (rst)
      (timeout && !irq_enable_reg && enable_reg) |=> guard_reset;
  endproperty
  a_reset_on_timeout: assert property (p_reset_on_timeout) else $error("missing timeout reset");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (rst)
      (irq_taken && !flag_set) |=> !flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_kick_restart;
    @(posedge clk_sys) disable iff (rst) guard_kick |=> count_reg == 21'h0;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (rst) !global_irq_enable |-> !timeout_irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");

endmodule
`default_nettype wire

// file: wdc_pkg.sv
// Package with constants for the watchdog timeout configuration block.
package wdc_pkg;
  // Register byte addresses (word aligned, Avalon-MM).
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h8;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'hc;
  // Control register field positions.
  localparam int BIT_IRQ_FLAG   = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_SEL3       = 5;
  localparam int BIT_UNLOCK     = 4;
  localparam int BIT_ENABLE     = 3;
  // Status register event bit positions.
  localparam int EV_TIMEOUT = 0;
  localparam int EV_RESET   = 1;
  localparam int EV_WIDTH   = 2;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Unlock window length in system clock cycles.
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Highest valid selector code; reserved codes fold onto it.
  localparam logic [3:0] SEL_MAX = 4'h9;
  // Shortest timeout exponent: code 0 gives 2^11 = 2K ticks.
  localparam int SEL_BASE_EXP = 11;
  // Program address of the reset vector and of the timeout vector.
  localparam logic [11:0] RESET_VECTOR   = 12'h000;
  localparam logic [11:0] TIMEOUT_VECTOR = 12'h00c;
  // Oscillator frequency of the timer tick.
  localparam int OSC_HZ = 128000;
  // States of the configuration unlock window.
  typedef enum logic [1:0] {
    WDC_IDLE = 2'b00,
    WDC_OPEN = 2'b01
  } wdc_unlock_t;
endpackage

// file: wdc_guard_tb.sv
// Self-checking testbench for the watchdog timeout configuration block.
`timescale 1ns/1ps
`default_nettype none
module wdc_guard_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        always_on_fuse = 1'b0;
  logic        osc_tick = 1'b0;
  logic        guard_kick = 1'b0;
  logic        global_irq_enable = 1'b0;
  logic        irq_taken = 1'b0;
  logic        guard_reset;
  logic [11:0] reset_vector_addr;
  logic        timeout_irq_req;
  logic [11:0] irq_vector_addr;
  logic        irq;
  logic        tick_slow = 1'b0;
  logic [31:0] rd;
  logic [7:0]  d;
  int          errors = 0;
  int          samples_checked = 0;
  int          resets_seen = 0;
  int          seed = 32'h42c1;
  int          n;
  int          snap;

  wdc_guard wdc_guard_inst (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .always_on_fuse(always_on_fuse), .osc_tick(osc_tick), .guard_kick(guard_kick),
    .global_irq_enable(global_irq_enable), .irq_taken(irq_taken),
    .guard_reset(guard_reset), .reset_vector_addr(reset_vector_addr),
    .timeout_irq_req(timeout_irq_req), .irq_vector_addr(irq_vector_addr), .irq(irq));

  // Clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  // Oscillator ticks every cycle, or every other cycle to prove the count follows ticks.
  always @(posedge clk_sys) osc_tick <= tick_slow ? !osc_tick : 1'b1;

  // Counts reset requests so that interrupt mode and kicks can show none were issued.
  always @(negedge clk_sys) if (guard_reset === 1'b1) resets_seen++;

  // Control value expected after a level 1 write: reserved selectors fold onto the top code.
  function automatic logic [31:0] exp_ctrl(input logic [7:0] v);
    logic [3:0] s;
    s = {v[5], v[2:0]};
    if (s > wdc_pkg::SEL_MAX) s = wdc_pkg::SEL_MAX;
    return {24'h0, 2'b00, s[3], 1'b0, v[3], s[2:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi)
    begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // One Avalon cycle; the request is held until waitrequest is sampled low at a rising edge.
  // Values read just after an edge are those from before it, as the design updates later.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask

  task automatic kick();
    @(posedge clk_sys);
    guard_kick <= 1'b1;
    @(posedge clk_sys);
    guard_kick <= 1'b0;
  endtask

  // Cycles from now until a reset request, bounded so a silent design cannot hang.
  task automatic measure(output int c);
    c = 0;
    @(negedge clk_sys);
    while (guard_reset !== 1'b1 && c < 20000)
    begin
      c++;
      @(negedge clk_sys);
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang costs far more than the roughly 50k cycles the sequence needs at worst.
  initial
  begin
    #280000;
    errors++;
    summarize();
  end

  // Main sequence: level 1 first, then a second reset with the fuse set for level 2.
  initial
  begin
    do_reset();
    rdc("ctrl_rst", wdc_pkg::ADDR_CONTROL, 32'h00);
    rdc("status_rst", wdc_pkg::ADDR_STATUS, 32'h0);
    rdc("unmapped", 4'h1, 32'h0);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h08);
    rdc("enable_free", wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h00);
    rdc("disable_locked", wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h18);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h00);
    rdc("disable_unlocked", wdc_pkg::ADDR_CONTROL, 32'h00);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h18);
    rdc("window_open", wdc_pkg::ADDR_CONTROL, 32'h18);
    repeat (8) @(posedge clk_sys);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h00);
    rdc("window_closed", wdc_pkg::ADDR_CONTROL, 32'h08);
    // Selector corners, then random selectors with the enable kept set.
    for (int i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 8'h2a : (i == 1) ? 8'h2f : (i == 2) ? 8'h29 : 8'h08 | ($random(seed) & 8'h27);
      bus(1'b1, wdc_pkg::ADDR_CONTROL, d);
      rdc("selector", wdc_pkg::ADDR_CONTROL, exp_ctrl(d));
    end
    // Shortest period, then the next code with ticks at half rate.
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h08);
    kick();
    measure(n);
    chk_rng("period_code0", 2040, 2060, n);
    chk("reset_vector", 32'h000, {20'h0, reset_vector_addr});
    tick_slow <= 1'b1;
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h09);
    kick();
    measure(n);
    chk_rng("period_code1_halfrate", 8180, 8210, n);
    tick_slow <= 1'b0;
    rdc("status_reset_event", wdc_pkg::ADDR_STATUS, 32'h2);
    bus(1'b1, wdc_pkg::ADDR_IRQ_EN, 8'h02);
    @(negedge clk_sys);
    chk("irq_enabled", 32'h1, {31'h0, irq});
    bus(1'b1, wdc_pkg::ADDR_IRQ_EN, 8'h00);
    @(negedge clk_sys);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, wdc_pkg::ADDR_IRQ_EN, 8'h02);
    bus(1'b1, wdc_pkg::ADDR_IRQ_CLR, 8'h02);
    @(negedge clk_sys);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdc("status_cleared", wdc_pkg::ADDR_STATUS, 32'h0);
    // Kicks at random spacing below the period keep the reset away.
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h08);
    kick();
    snap = resets_seen;
    for (int i = 0; i < 20; i++)
    begin
      repeat (100 + ($unsigned($random(seed)) % 1500)) @(posedge clk_sys);
      kick();
    end
    chk("kicked_no_reset", snap, resets_seen);
    // Unlock, then interrupt mode with the enable cleared.
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h18);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h40);
    snap = resets_seen;
    repeat (2200) @(posedge clk_sys);
    rdc("flag_set", wdc_pkg::ADDR_CONTROL, 32'hc0);
    rdc("status_timeout_event", wdc_pkg::ADDR_STATUS, 32'h1);
    chk("req_global_off", 32'h0, {31'h0, timeout_irq_req});
    global_irq_enable <= 1'b1;
    @(negedge clk_sys);
    chk("req_global_on", 32'h1, {31'h0, timeout_irq_req});
    chk("irq_vector", 32'h00c, {20'h0, irq_vector_addr});
    @(posedge clk_sys);
    irq_taken <= 1'b1;
    @(posedge clk_sys);
    irq_taken <= 1'b0;
    @(negedge clk_sys);
    chk("req_after_taken", 32'h0, {31'h0, timeout_irq_req});
    rdc("flag_taken_clear", wdc_pkg::ADDR_CONTROL, 32'h40);
    repeat (2200) @(posedge clk_sys);
    rdc("flag_again", wdc_pkg::ADDR_CONTROL, 32'hc0);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'hc0);
    rdc("flag_write_clear", wdc_pkg::ADDR_CONTROL, 32'h40);
    chk("irq_mode_no_reset", snap, resets_seen);
    // Safety level 2.
    global_irq_enable <= 1'b0;
    always_on_fuse <= 1'b1;
    do_reset();
    rdc("l2_enable_reads_one", wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h00);
    rdc("l2_no_disable", wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h09);
    rdc("l2_selector_locked", wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h18);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 8'h03);
    rdc("l2_selector_changed", wdc_pkg::ADDR_CONTROL, 32'h0b);
    summarize();
  end
endmodule
`default_nettype wire
